// *** verilog/csr_ring_pkg.sv ***
// Shared constants and types for the register ring agent.
package csr_ring_pkg;

   // Widths of the ring and of the local register port.
   localparam int RING_CTL_W      = 4;
   localparam int RING_DATA_W     = 16;
   localparam int REG_INDEX_W     = 16;
   localparam int REG_VALUE_W     = 64;
   localparam int WORDS_PER_VALUE = REG_VALUE_W / RING_DATA_W;

   // Ring control codes carried beside each ring data word.
   localparam logic [3:0] CTL_IDLE    = 4'h0;
   localparam logic [3:0] CTL_WR_HDR  = 4'h1;
   localparam logic [3:0] CTL_RD_HDR  = 4'h2;
   localparam logic [3:0] CTL_WR_DATA = 4'h3;
   localparam logic [3:0] CTL_RD_RESP = 4'h4;

   // Default selection parameters of one agent.
   localparam logic [15:0] SEL_MASK_DEFAULT  = 16'hf000;
   localparam logic [15:0] SEL_MATCH_DEFAULT = 16'h8000;

   // Beat counting of a 64-bit value split into four ring words.
   localparam logic [1:0] BEAT_FIRST = 2'h0;
   localparam logic [1:0] BEAT_STEP  = 2'h1;
   localparam logic [1:0] BEAT_LAST  = 2'h3;

   // Reset values.
   localparam logic [15:0] RING_DATA_RESET = 16'h0000;
   localparam logic [15:0] INDEX_RESET     = 16'h0000;
   localparam logic [63:0] VALUE_RESET     = 64'h0000_0000_0000_0000;

   // Write frame tracking states.
   typedef enum logic [1:0] {
      FRAME_IDLE = 2'b00,
      FRAME_OWN  = 2'b01
   } frame_state_e;

   // Read transaction states, Gray coded along idle, wait, send.
   typedef enum logic [1:0] {
      RESP_IDLE = 2'b00,
      RESP_WAIT = 2'b01,
      RESP_SEND = 2'b11
   } resp_state_e;

endpackage

// *** verilog/ring_frame_tracker.sv ***
// Ring frame decoder: selection, address capture and write data assembly.
`timescale 1ns/1ps
module ring_frame_tracker
   import csr_ring_pkg::*;
#(
   parameter logic [15:0] SEL_MASK  = SEL_MASK_DEFAULT,
   parameter logic [15:0] SEL_MATCH = SEL_MATCH_DEFAULT
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   input  wire logic        i_clear,
   input  wire logic        i_read_block,
   input  wire logic [3:0]  i_ring_ctl,
   input  wire logic [15:0] i_ring_data,
   output logic             o_own_word,
   output logic             o_wr_pulse,
   output logic             o_rd_pulse,
   output logic [15:0]      o_index,
   output logic [63:0]      o_value
);

   frame_state_e state;
   logic [1:0]   beat;
   logic         hit;
   logic         wr_hdr;
   logic         rd_hdr;
   logic         own_data;

   // A header word carries the access address; the agent claims it on a mask match.
   assign hit      = (i_ring_data & SEL_MASK) == SEL_MATCH;
   assign wr_hdr   = (state == FRAME_IDLE) && (i_ring_ctl == CTL_WR_HDR) && hit;
   assign rd_hdr   = (state == FRAME_IDLE) && (i_ring_ctl == CTL_RD_HDR) && hit && !i_read_block;
   assign own_data = (state == FRAME_OWN) && (i_ring_ctl == CTL_WR_DATA);
   assign o_own_word = wr_hdr || rd_hdr || own_data;

   // Frame state: only writes span several words, reads are one header word.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         state <= FRAME_IDLE;
      end else if (i_clear) begin
         state <= FRAME_IDLE;
      end else begin
         case (state)
            FRAME_IDLE: begin
               if (wr_hdr) begin
                  state <= FRAME_OWN;
               end
            end
            FRAME_OWN: begin
               if (own_data && (beat == BEAT_LAST)) begin
                  state <= FRAME_IDLE;
               end
            end
            default: begin
               state <= FRAME_IDLE;
            end
         endcase
      end
   end

   // Beat counter of the write data words.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         beat <= BEAT_FIRST;
      end else if (i_clear || wr_hdr) begin
         beat <= BEAT_FIRST;
      end else if (own_data) begin
         beat <= 2'(beat + BEAT_STEP);
      end
   end

   // The index is the address with the selection bits removed, so it is zero based.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_index <= INDEX_RESET;
      end else if (wr_hdr || rd_hdr) begin
         o_index <= i_ring_data & ~SEL_MASK;
      end
   end

   // Low word arrives first and is shifted down, so after four beats it sits in bits 15:0.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_value <= VALUE_RESET;
      end else if (own_data) begin
         o_value <= {i_ring_data, o_value[63:16]};
      end
   end

   // Strobes are registered so that index and value are settled in the same cycle.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_wr_pulse <= 1'b0;
         o_rd_pulse <= 1'b0;
      end else begin
         o_wr_pulse <= !i_clear && own_data && (beat == BEAT_LAST);
         o_rd_pulse <= !i_clear && rd_hdr;
      end
   end

endmodule // ring_frame_tracker

// *** verilog/read_resp_serializer.sv ***
// Splits a captured 64-bit read value into four ring words sent in free slots.
`timescale 1ns/1ps
module read_resp_serializer
   import csr_ring_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   input  wire logic        i_clear,
   input  wire logic        i_load,
   input  wire logic [63:0] i_value,
   input  wire logic        i_slot_free,
   output logic             o_word_valid,
   output logic [15:0]      o_word,
   output logic             o_busy
);

   logic [63:0] shreg;
   logic [1:0]  sent;
   logic        sending;

   // A word goes out only when the ring brings an idle slot, so no through traffic is lost.
   assign o_word_valid = sending && i_slot_free;
   assign o_word       = shreg[15:0];
   assign o_busy       = sending;

   // Load, shift and count the response words, low word first.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         shreg   <= VALUE_RESET;
         sent    <= BEAT_FIRST;
         sending <= 1'b0;
      end else if (i_clear) begin
         sent    <= BEAT_FIRST;
         sending <= 1'b0;
      end else if (i_load) begin
         shreg   <= i_value;
         sent    <= BEAT_FIRST;
         sending <= 1'b1;
      end else if (o_word_valid) begin
         shreg <= {RING_DATA_RESET, shreg[63:16]};
         sent  <= 2'(sent + BEAT_STEP);
         if (sent == BEAT_LAST) begin
            sending <= 1'b0;
         end
      end
   end

endmodule // read_resp_serializer

// *** verilog/csr_ring_agent_register_port.sv ***
// Register agent on the management ring with a strobe-based local register port.
//
// Functional notes
// - Agent takes 4-bit ring control and 16-bit ring data from the previous hop.
// - Agent drives 4-bit ring control and 16-bit ring data to the next hop.
// - Mask and match parameters pick own accesses, turned into register reads and writes.
// - Any number of agents may sit on the ring, each near its logic.
// - Agent and target logic are cleared by a synchronous active-low reset.
// - A write pulses the write strobe one cycle with index and value valid.
// - A read pulses the read strobe one cycle with a valid index.
// - The 16-bit zero-based index is meaningful only while a strobe is high.
// - The 64-bit write value is meaningful only while the write strobe is high.
// - Agent captures the read value on read-done and returns it on the ring.
// - Agent is selected when mask AND address equals the match value.
`timescale 1ns/1ps
module csr_ring_agent_register_port
   import csr_ring_pkg::*;
#(
   parameter logic [15:0] SEL_MASK  = SEL_MASK_DEFAULT,
   parameter logic [15:0] SEL_MATCH = SEL_MATCH_DEFAULT
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   input  wire logic        i_csr_reset_n,
   input  wire logic [3:0]  i_ring_ctl,
   input  wire logic [15:0] i_ring_data,
   output logic [3:0]       o_ring_ctl,
   output logic [15:0]      o_ring_data,
   output logic             o_reg_write,
   output logic             o_reg_read,
   output logic [15:0]      o_reg_index,
   output logic [63:0]      o_reg_write_value,
   input  wire logic        i_reg_read_done,
   input  wire logic [63:0] i_reg_read_value
);

   resp_state_e resp_state;
   logic        clear;
   logic        own_word;
   logic        wr_pulse;
   logic        rd_pulse;
   logic [15:0] index;
   logic [63:0] wr_value;
   logic        capture;
   logic        resp_valid;
   logic [15:0] resp_word;
   logic        resp_busy;
   logic        slot_free;
   logic [2:0]  resp_words;

   // The synchronous register reset clears the agent alongside its target logic.
   assign clear = !i_csr_reset_n;

   // A read value is accepted only while a read is outstanding; stray answers are dropped.
   assign capture = (resp_state == RESP_WAIT) && i_reg_read_done;

   // Only an idle ring slot may carry a response word.
   assign slot_free = (i_ring_ctl == CTL_IDLE);

   // Frame decoding and selection; the ring is same-clock logic, so no synchroniser.
   // A read whose strobe is out already counts as outstanding, so a header right behind it is refused.
   ring_frame_tracker #(
      .SEL_MASK  (SEL_MASK),
      .SEL_MATCH (SEL_MATCH)
   ) u_tracker (
      .i_core_clk   (i_core_clk),
      .i_reset      (i_reset),
      .i_clear      (clear),
      .i_read_block ((resp_state != RESP_IDLE) || rd_pulse),
      .i_ring_ctl   (i_ring_ctl),
      .i_ring_data  (i_ring_data),
      .o_own_word   (own_word),
      .o_wr_pulse   (wr_pulse),
      .o_rd_pulse   (rd_pulse),
      .o_index      (index),
      .o_value      (wr_value)
   );

   // Response words are queued in the serializer while the ring carries other traffic.
   read_resp_serializer u_resp (
      .i_core_clk   (i_core_clk),
      .i_reset      (i_reset),
      .i_clear      (clear),
      .i_load       (capture),
      .i_value      (i_reg_read_value),
      .i_slot_free  (slot_free),
      .o_word_valid (resp_valid),
      .o_word       (resp_word),
      .o_busy       (resp_busy)
   );

   // The local port mirrors flip-flops inside the tracker, so it is glitch free.
   assign o_reg_write       = wr_pulse;
   assign o_reg_read        = rd_pulse;
   assign o_reg_index       = index;
   assign o_reg_write_value = wr_value;

   // One read may be outstanding; a second read header meanwhile passes on unclaimed.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         resp_state <= RESP_IDLE;
      end else if (clear) begin
         resp_state <= RESP_IDLE;
      end else begin
         case (resp_state)
            RESP_IDLE: begin
               if (rd_pulse) begin
                  resp_state <= RESP_WAIT;
               end
            end
            RESP_WAIT: begin
               if (capture) begin
                  resp_state <= RESP_SEND;
               end
            end
            RESP_SEND: begin
               if (resp_valid && !resp_busy) begin
                  resp_state <= RESP_IDLE;
               end else if (!resp_busy) begin
                  resp_state <= RESP_IDLE;
               end
            end
            default: begin
               resp_state <= RESP_IDLE;
            end
         endcase
      end
   end

   // Ring output stage: claimed words become idle, through traffic wins over responses.
   // Forwarding costs one cycle of latency per agent, which keeps every output a flop.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_ring_ctl  <= CTL_IDLE;
         o_ring_data <= RING_DATA_RESET;
      end else if (clear) begin
         o_ring_ctl  <= CTL_IDLE;
         o_ring_data <= RING_DATA_RESET;
      end else if (own_word) begin
         o_ring_ctl  <= CTL_IDLE;
         o_ring_data <= RING_DATA_RESET;
      end else if (!slot_free) begin
         o_ring_ctl  <= i_ring_ctl;
         o_ring_data <= i_ring_data;
      end else if (resp_valid) begin
         o_ring_ctl  <= CTL_RD_RESP;
         o_ring_data <= resp_word;
      end else begin
         o_ring_ctl  <= i_ring_ctl;
         o_ring_data <= i_ring_data;
      end
   end

   // Helper for checks: counts response words sent during one read.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         resp_words <= 3'h0;
      end else if (clear || capture) begin
         resp_words <= 3'h0;
      end else if (resp_valid && !own_word) begin
         resp_words <= 3'(resp_words + 3'h1);
      end
   end

   // The write strobe never stands two cycles.
   property p_wr_single;
      @(posedge i_core_clk) disable iff (i_reset)
      o_reg_write |=> !o_reg_write;
   endproperty
   a_wr_single: assert property (p_wr_single) else $error("write strobe longer than one cycle");

   // The read strobe never stands two cycles.
   property p_rd_single;
      @(posedge i_core_clk) disable iff (i_reset)
      o_reg_read |=> !o_reg_read;
   endproperty
   a_rd_single: assert property (p_rd_single) else $error("read strobe longer than one cycle");

   // Both strobes never share a cycle, so the index has one meaning.
   property p_strobe_excl;
      @(posedge i_core_clk) disable iff (i_reset)
      !(o_reg_write && o_reg_read);
   endproperty
   a_strobe_excl: assert property (p_strobe_excl) else $error("read and write strobe together");

   // A claimed read header raises the read strobe with the zero-based index next cycle.
   property p_rd_from_hdr;
      @(posedge i_core_clk) disable iff (i_reset)
      (own_word && i_ring_ctl == CTL_RD_HDR && i_csr_reset_n)
         |=> o_reg_read && (o_reg_index == ($past(i_ring_data) & ~SEL_MASK));
   endproperty
   a_rd_from_hdr: assert property (p_rd_from_hdr) else $error("read header did not raise read strobe");

   // The index of a strobe never carries the selection bits.
   property p_index_local;
      @(posedge i_core_clk) disable iff (i_reset)
      (o_reg_write || o_reg_read) |-> ((o_reg_index & SEL_MASK) == 16'h0000);
   endproperty
   a_index_local: assert property (p_index_local) else $error("index holds selection bits");

   // A non-matching header is never claimed.
   property p_no_claim_miss;
      @(posedge i_core_clk) disable iff (i_reset)
      ((i_ring_ctl == CTL_WR_HDR || i_ring_ctl == CTL_RD_HDR) && ((i_ring_data & SEL_MASK) != SEL_MATCH))
         |-> !own_word;
   endproperty
   a_no_claim_miss: assert property (p_no_claim_miss) else $error("agent claimed a foreign header");

   // Unclaimed traffic appears unchanged one cycle later.
   property p_forward;
      @(posedge i_core_clk) disable iff (i_reset)
      (!own_word && i_ring_ctl != CTL_IDLE && i_csr_reset_n)
         |=> (o_ring_ctl == $past(i_ring_ctl)) && (o_ring_data == $past(i_ring_data));
   endproperty
   a_forward: assert property (p_forward) else $error("through traffic altered");

   // Claimed words leave the ring as idle slots.
   property p_consume;
      @(posedge i_core_clk) disable iff (i_reset)
      (own_word && i_csr_reset_n) |=> (o_ring_ctl == CTL_IDLE);
   endproperty
   a_consume: assert property (p_consume) else $error("claimed word reached ring output");

   // The captured value leaves in order, low word first in the first free slot.
   property p_resp_word;
      @(posedge i_core_clk) disable iff (i_reset)
      (resp_valid && !own_word && i_csr_reset_n)
         |=> (o_ring_ctl == CTL_RD_RESP) && (o_ring_data == $past(resp_word));
   endproperty
   a_resp_word: assert property (p_resp_word) else $error("response word not driven");

   // Read-done in the wait state starts the response, which is four words long.
   property p_capture;
      @(posedge i_core_clk) disable iff (i_reset)
      (capture && i_csr_reset_n) |=> (resp_state == RESP_SEND) && resp_busy
         && (resp_word == $past(i_reg_read_value[15:0]));
   endproperty
   a_capture: assert property (p_capture) else $error("read value not captured");

   // A response ends after exactly four words.
   property p_resp_count;
      @(posedge i_core_clk) disable iff (i_reset)
      (resp_state == RESP_SEND && !resp_busy && i_csr_reset_n) |-> (resp_words == 3'h4);
   endproperty
   a_resp_count: assert property (p_resp_count) else $error("response word count wrong");

   // The register reset silences the strobes and the ring within one cycle.
   property p_sync_clear;
      @(posedge i_core_clk) disable iff (i_reset)
      !i_csr_reset_n |=> !o_reg_write && !o_reg_read && (o_ring_ctl == CTL_IDLE)
         && (resp_state == RESP_IDLE);
   endproperty
   a_sync_clear: assert property (p_sync_clear) else $error("register reset not obeyed");

   // A read header behind an outstanding or just strobed read passes on unclaimed.
   property p_rd_block;
      @(posedge i_core_clk) disable iff (i_reset)
      ((o_reg_read || resp_state != RESP_IDLE) && i_ring_ctl == CTL_RD_HDR) |-> !own_word;
   endproperty
   a_rd_block: assert property (p_rd_block) else $error("second read header claimed");

   // The write strobe only follows a claimed write data word.
   property p_wr_after_data;
      @(posedge i_core_clk) disable iff (i_reset)
      o_reg_write |-> $past(own_word) && ($past(i_ring_ctl) == CTL_WR_DATA);
   endproperty
   a_wr_after_data: assert property (p_wr_after_data) else $error("write strobe without data word");

   // The index is settled before the write strobe and does not move under it.
   property p_wr_index_stable;
      @(posedge i_core_clk) disable iff (i_reset)
      o_reg_write |-> $stable(o_reg_index);
   endproperty
   a_wr_index_stable: assert property (p_wr_index_stable) else $error("index moved at write strobe");

   // A read strobe leaves the agent waiting for the answer of the target.
   property p_rd_wait;
      @(posedge i_core_clk) disable iff (i_reset)
      (o_reg_read && i_csr_reset_n) |=> (resp_state == RESP_WAIT);
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read strobe did not start a wait");

   // No response can start unless a read is waiting for its answer.
   property p_no_stray;
      @(posedge i_core_clk) disable iff (i_reset)
      (resp_state == RESP_IDLE && i_csr_reset_n) |=> !resp_busy;
   endproperty
   a_no_stray: assert property (p_no_stray) else $error("response started without a read");

   // An idle slot with no response word to carry passes on as it came.
   property p_idle_forward;
      @(posedge i_core_clk) disable iff (i_reset)
      (slot_free && !resp_valid && i_csr_reset_n)
         |=> (o_ring_ctl == CTL_IDLE) && (o_ring_data == $past(i_ring_data));
   endproperty
   a_idle_forward: assert property (p_idle_forward) else $error("idle slot altered");

endmodule // csr_ring_agent_register_port

// *** test/reg_target_model.sv ***
// Behavioural target logic behind the agent: a small register file that answers reads.
`timescale 1ns/1ps
module reg_target_model
   import csr_ring_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_csr_reset_n,
   input  wire logic        i_reg_write,
   input  wire logic        i_reg_read,
   input  wire logic [15:0] i_reg_index,
   input  wire logic [63:0] i_reg_write_value,
   input  wire logic [3:0]  i_delay,
   output logic             o_reg_read_done,
   output logic [63:0]      o_reg_read_value
);
   logic [63:0] mem [16];
   logic        pend;
   logic [3:0]  cnt;
   logic [3:0]  idx;

   // Index and value are only looked at in a strobe cycle, never between strobes.
   always_ff @(posedge i_core_clk) begin
      if (i_reg_write) begin
         mem[i_reg_index[3:0]] <= i_reg_write_value;
      end
   end

   // One read-done per strobe after a chosen wait; the value bus churns otherwise,
   // so an agent that captures it in the wrong cycle picks up garbage.
   always_ff @(posedge i_core_clk) begin
      o_reg_read_done  <= 1'b0;
      o_reg_read_value <= ~o_reg_read_value;
      if (!i_csr_reset_n) begin
         pend             <= 1'b0;
         o_reg_read_value <= 64'h0000_0000_0000_0000;
      end else if (i_reg_read) begin
         pend <= 1'b1;
         cnt  <= i_delay;
         idx  <= i_reg_index[3:0];
      end else if (pend && cnt == 4'h0) begin
         o_reg_read_done  <= 1'b1;
         o_reg_read_value <= mem[idx];
         pend             <= 1'b0;
      end else if (pend) begin
         cnt <= cnt - 4'h1;
      end
   end
endmodule // reg_target_model

// *** test/tb_csr_ring_agent_register_port.sv ***
// Self-checking testbench for the register ring agent with a target model behind it.
`timescale 1ns/1ps
module tb_csr_ring_agent_register_port;
   import csr_ring_pkg::*;

   logic        core_clk;
   logic        reset;
   logic        csr_reset_n;
   logic [3:0]  ring_ctl_in;
   logic [15:0] ring_data_in;
   logic [3:0]  ring_ctl_out;
   logic [15:0] ring_data_out;
   logic        reg_write;
   logic        reg_read;
   logic [15:0] reg_index;
   logic [63:0] reg_write_value;
   logic        read_done;
   logic [63:0] read_value;
   logic [3:0]  delay;
   int          fails;
   int          checks_done;

   // The bench plays the management port and closes the ring through this one agent.
   csr_ring_agent_register_port u_dut (
      .i_core_clk        (core_clk),
      .i_reset           (reset),
      .i_csr_reset_n     (csr_reset_n),
      .i_ring_ctl        (ring_ctl_in),
      .i_ring_data       (ring_data_in),
      .o_ring_ctl        (ring_ctl_out),
      .o_ring_data       (ring_data_out),
      .o_reg_write       (reg_write),
      .o_reg_read        (reg_read),
      .o_reg_index       (reg_index),
      .o_reg_write_value (reg_write_value),
      .i_reg_read_done   (read_done),
      .i_reg_read_value  (read_value)
   );

   reg_target_model u_target (
      .i_core_clk        (core_clk),
      .i_csr_reset_n     (csr_reset_n),
      .i_reg_write       (reg_write),
      .i_reg_read        (reg_read),
      .i_reg_index       (reg_index),
      .i_reg_write_value (reg_write_value),
      .i_delay           (delay),
      .o_reg_read_done   (read_done),
      .o_reg_read_value  (read_value)
   );

   // A 50 ns period gives the 20 MHz register clock.
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Compares one value and counts the outcome.
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Presents one ring word at the falling edge and returns once the agent has taken it.
   task automatic step(input logic [3:0] c, input logic [15:0] d, input logic rn = 1'b1);
      @(negedge core_clk);
      ring_ctl_in  = c;
      ring_data_in = d;
      csr_reset_n  = rn;
      @(posedge core_clk);
      #1;
   endtask

   // Words not addressed to this agent travel on unchanged, one cycle later.
   task automatic t_forward;
      logic [15:0] addrs [5];
      addrs = '{16'h9005, 16'h7fff, 16'h0000, 16'hffff, 16'ha123};
      for (int c = 0; c < 5; c++) begin
         step(4'(c), addrs[c]);
         check({ring_ctl_out, ring_data_out}, {4'(c), addrs[c]});
         check(reg_write | reg_read, 1'b0);
      end
      $display("test forward done");
   endtask

   // A claimed write frame yields one strobe carrying the assembled value.
   task automatic t_write(input logic [15:0] addr, input logic [63:0] v);
      step(CTL_WR_HDR, addr);
      check({ring_ctl_out, ring_data_out}, 20'h0_0000);
      for (int k = 0; k < 4; k++) begin
         step(CTL_WR_DATA, v[16*k+:16]);
         check(reg_write, k == 3);
      end
      check(reg_index, addr & ~SEL_MASK_DEFAULT);
      check(reg_write_value, v);
      step(CTL_IDLE, 16'h0000);
      check(reg_write, 1'b0);
      $display("test write done");
   endtask

   // A read is strobed once, a second header is refused, and the answer returns in four words.
   task automatic t_read(input logic [15:0] addr, input logic [63:0] exp, input logic [3:0] dly);
      logic [63:0] got;
      int          n;
      bit          fwd;
      got   = 64'h0;
      n     = 0;
      fwd   = 1'b0;
      delay = dly;
      step(CTL_RD_HDR, addr);
      check(reg_read, 1'b1);
      check(reg_index, addr & ~SEL_MASK_DEFAULT);
      step(CTL_RD_HDR, addr);
      check(reg_read, 1'b0);
      check({ring_ctl_out, ring_data_out}, {CTL_RD_HDR, addr});
      for (int i = 0; i < 40; i++) begin
         if (n == 2 && !fwd) begin
            fwd = 1'b1;
            step(CTL_WR_HDR, 16'h1234);
            check({ring_ctl_out, ring_data_out}, {CTL_WR_HDR, 16'h1234});
         end else begin
            step(CTL_IDLE, 16'h0000);
         end
         if (ring_ctl_out === CTL_RD_RESP) begin
            if (n < 4) got[16*n+:16] = ring_data_out;
            n++;
         end
      end
      check(n, 4);
      check(got, exp);
      $display("test read done");
   endtask

   // A register reset in mid-read and mid-frame drops both transactions.
   task automatic t_csr_reset;
      delay = 4'h3;
      step(CTL_RD_HDR, 16'h8005);
      step(CTL_WR_HDR, 16'h8002);
      step(CTL_WR_DATA, 16'h0001, 1'b0);
      check({ring_ctl_out, ring_data_out, reg_write, reg_read}, 22'h0);
      for (int i = 0; i < 10; i++) begin
         step(CTL_WR_DATA, 16'(i));
         check(reg_write, 1'b0);
         check(ring_ctl_out, CTL_WR_DATA);
      end
      $display("test csr reset done");
   endtask

   // Verdict and end of run.
   task automatic close_out;
      $display("checks_done=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // The tests need under two hundred cycles; 4000 leaves ample room before calling it a hang.
   initial begin
      #(4000 * 50);
      fails++;
      close_out();
   end

   // Main sequence.
   initial begin
      fails        = 0;
      checks_done  = 0;
      reset        = 1'b1;
      csr_reset_n  = 1'b0;
      ring_ctl_in  = CTL_IDLE;
      ring_data_in = 16'h0000;
      delay        = 4'h0;
      repeat (16) @(negedge core_clk);
      check({ring_ctl_out, ring_data_out, reg_write, reg_read}, 22'h0);
      reset       = 1'b0;
      csr_reset_n = 1'b1;
      t_forward();
      t_write(16'h8005, 64'h0123_4567_89ab_cdef);
      t_write(16'h8fff, 64'hfedc_ba98_7654_3210);
      t_read(16'h8005, 64'h0123_4567_89ab_cdef, 4'h0);
      t_read(16'h8fff, 64'hfedc_ba98_7654_3210, 4'h6);
      t_csr_reset();
      t_read(16'h8005, 64'h0123_4567_89ab_cdef, 4'h2);
      close_out();
   end
endmodule // tb_csr_ring_agent_register_port
